// File: rtl/sdmzp_pkg.sv
// Constants shared by the mode-register-write, calibration and power-down block.
// Assumes one command clock CORE_CLK at 200 MHz; the CA bus arrives as two samples per cycle.
// Notes on behaviour
// R01: CS low, CA3..CA0 low decodes a write
// R02: Register number is CA1f-CA0f above CA9r-CA4r
// R03: Written byte is falling-edge CA9..CA2
// R04: Writes to read-only registers change nothing
// R05: Controller writes only with all banks idle
// R06: Only NOPs during write period, then idle
// R07: Mode reads allowed idle or active, state kept
// R08: Reset write restores defaults, enters auto-init
// R09: Controller keeps boot timings after reset write
// R10: Four calibrations, each with own busy period
// R11: Controller runs init calibration, long/short later
// R12: Calibration reset restores default drive, no quiet
// R13: Calibration only when idle, data bus quiet
// R14: Shared resistor: no overlapping calibrations except reset
// R15: Calibration pin at supply: ignore calibrations
// R16: Calibration done switches calibration current off
// R17: Only NOPs and CKE high while calibrating
// R18: CKE falling with CS high enters power-down
// R19: CKE not lowered during mode or data operations
// R20: Idle or active power-down, buffers off
// R21: No refresh during power-down
// R22: CKE high with CS high exits, tCKE, tXP
// R23: NOP is CS high or CA2..CA0 high
// R24: Busy windows counted; non-NOP inside flagged illegal
// R25: Bank state tracked; writes while active rejected
package sdmzp_pkg;
    // ******************************
    // Timing
    // ******************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_MRW_NS = 10;
    localparam int T_CKE_NS = 15;
    localparam int T_XP_NS = 15;
    localparam int T_ZQINIT_NS = 1000;
    localparam int T_ZQCL_NS = 360;
    localparam int T_ZQCS_NS = 90;
    localparam int T_ZQRESET_NS = 50;
    localparam int T_INIT_NS = 1000;
    localparam int MRW_CYC = (T_MRW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CKE_CYC = (T_CKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int XP_CYC = (T_XP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ZQINIT_CYC = (T_ZQINIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ZQCL_CYC = (T_ZQCL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ZQCS_CYC = (T_ZQCS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ZQRESET_CYC = (T_ZQRESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INIT_CYC = (T_INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
    // Synchroniser contents after reset: CKE and CS_N at idle high, all else low
    localparam logic [23:0] PIN_IDLE = 24'h30_0000;
    // ******************************
    // Mode register map
    // ******************************
    localparam logic [7:0] MA_RESET = 8'h3F;
    localparam logic [7:0] MA_ZQ = 8'h0A;
    localparam logic [7:0] ZQ_INIT_CODE = 8'hFF;
    localparam logic [7:0] ZQ_LONG_CODE = 8'hAB;
    localparam logic [7:0] ZQ_SHORT_CODE = 8'h56;
    localparam logic [7:0] ZQ_RESET_CODE = 8'hC3;
    localparam logic [7:0] MA_WR_LO = 8'h01;
    localparam logic [7:0] MA_WR_HI = 8'h03;
    localparam logic [7:0] MR_DEFAULT = 8'h00;
    localparam logic [3:0] DRIVE_DEFAULT = 4'h0;
    localparam logic [3:0] DRIVE_CAL = 4'h1;
    // ******************************
    // States
    // ******************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_MRW = 6'b00_0010,
        ST_INIT = 6'b00_0100,
        ST_ZQ = 6'b00_1000,
        ST_PD = 6'b01_0000,
        ST_XP = 6'b10_0000
    } sdmzp_state_type;
endpackage

// File: rtl/sdmzp_mr_mem.sv
// Small mode register store with registered read data.
// Assumes writes and reads come from logic on CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module sdmzp_mr_mem
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic clr_all,
    // Read side
    input wire logic [1:0] rd_addr,
    output logic [7:0] rd_data
);
    import sdmzp_pkg::*;
    logic [7:0] mem_r [4];
    // One writable register per entry
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ent
            always_ff @(posedge clk)
            begin
                if (!rst_n || clr_all)
                    mem_r[gi] <= MR_DEFAULT;
                else if (wr_en && wr_addr == 2'(gi))
                    mem_r[gi] <= wr_data;
            end
        end
    endgenerate
    // Registered read port
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rd_data <= MR_DEFAULT;
        else
            rd_data <= mem_r[rd_addr];
    end
endmodule
`default_nettype wire

// File: rtl/sdmzp_top.sv
// Device-side command logic: mode register writes, calibration and power-down.
// Assumes the controller delivers CS_N, CKE, CA rising and falling samples as pins.
`timescale 1ns/1ps
`default_nettype none
module sdmzp_top
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Command pins
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic [9:0] CA_RISE,
    input wire logic [9:0] CA_FALL,
    // Bank and pin straps, mode register read address
    input wire logic BANK_ACTIVE,
    input wire logic ZQ_AT_SUPPLY,
    input wire logic [1:0] MR_RD_ADDR,
    // Status outputs
    output logic [7:0] MR_RD_DATA,
    output logic BUSY,
    output logic POWER_DOWN,
    output logic ACTIVE_PD,
    output logic BUFFERS_ON,
    output logic ZQ_CURRENT_ON,
    output logic [3:0] OUTPUT_DRIVE_IMPEDANCE,
    output logic ILLEGAL_CMD,
    output logic REJECTED_CMD,
    output logic INIT_ACTIVE
);
    import sdmzp_pkg::*;
    // ******************************
    // Input synchronisers
    // ******************************
    localparam int PW = 24;
    logic [PW-1:0] s1_r, s2_r, s3_r, pin_r;
    logic cke, cs_n, bank_act, zq_sup;
    logic [9:0] ca_r, ca_f;
    // Three stages; a change counts once stage two and three agree
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
            s3_r <= PIN_IDLE;
            pin_r <= PIN_IDLE;
        end
        else
        begin
            s1_r <= {ZQ_AT_SUPPLY, BANK_ACTIVE, CKE, CS_N, CA_RISE, CA_FALL};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < PW; i++)
                if (s2_r[i] == s3_r[i])
                    pin_r[i] <= s3_r[i];
        end
    end
    assign {zq_sup, bank_act, cke, cs_n, ca_r, ca_f} = pin_r;
    // ******************************
    // Command decode
    // ******************************
    logic cke_prev_r;
    logic cs_n_prev_r;
    logic cmd_start;
    logic is_nop, is_mrw, is_pde;
    logic [7:0] ma, op;
    logic mr_writable;
    logic [7:0] zq_len;
    logic zq_cmd;
    assign is_nop = cs_n || (ca_r[2:0] == 3'b111); // [R23]
    // The controller holds CS low two cycles so the input filter passes it; count one command per low run
    assign cmd_start = !cs_n && cs_n_prev_r;
    assign is_mrw = cke && cke_prev_r && cmd_start && ca_r[3:0] == 4'b0000; // [R01]
    assign ma = {ca_f[1:0], ca_r[9:4]}; // [R02]
    assign op = ca_f[9:2]; // [R03]
    assign mr_writable = ma >= MA_WR_LO && ma <= MA_WR_HI;
    assign zq_cmd = ma == MA_ZQ && (op == ZQ_INIT_CODE || op == ZQ_LONG_CODE ||
                                    op == ZQ_SHORT_CODE || op == ZQ_RESET_CODE);
    assign is_pde = cke_prev_r && !cke && cs_n; // [R18]
    // Calibration period by command code
    always_comb
    begin
        zq_len = 8'h00;
        unique case (op)
            ZQ_INIT_CODE: zq_len = 8'(ZQINIT_CYC); // [R10]
            ZQ_LONG_CODE: zq_len = 8'(ZQCL_CYC);
            ZQ_SHORT_CODE: zq_len = 8'(ZQCS_CYC);
            default: zq_len = 8'(ZQRESET_CYC);
        endcase
    end
    // Previous CKE and CS levels, reset to their idle high
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            cke_prev_r <= 1'b1;
            cs_n_prev_r <= 1'b1;
        end
        else
        begin
            cke_prev_r <= cke;
            cs_n_prev_r <= cs_n;
        end
    end
    // ******************************
    // Main state machine
    // ******************************
    sdmzp_state_type state_r;
    logic [CNT_W-1:0] cnt_r;
    logic cnt_done;
    logic accept_mrw;
    logic zq_reset_r;
    assign cnt_done = cnt_r == '0;
    assign accept_mrw = state_r == ST_IDLE && is_mrw && !bank_act; // [R25]
    // State and busy counter
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (is_pde)
                    begin
                        state_r <= ST_PD; // [R20]
                        cnt_r <= CNT_W'(CKE_CYC - 1);
                    end
                    else if (accept_mrw && ma == MA_RESET)
                    begin
                        state_r <= ST_INIT; // [R08]
                        cnt_r <= CNT_W'(INIT_CYC - 1);
                    end
                    else if (accept_mrw && zq_cmd && !zq_sup)
                    begin
                        state_r <= ST_ZQ; // [R10]
                        cnt_r <= CNT_W'(zq_len - 8'h01);
                    end
                    else if (accept_mrw)
                    begin
                        state_r <= ST_MRW; // [R06]
                        cnt_r <= CNT_W'(MRW_CYC - 1);
                    end
                end
                ST_MRW, ST_INIT, ST_ZQ:
                begin
                    if (cnt_done)
                        state_r <= ST_IDLE; // [R24]
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                ST_PD:
                begin
                    if (!cnt_done)
                        cnt_r <= cnt_r - 1'b1;
                    // Exit only after minimum low time
                    else if (cke && cs_n)
                    begin
                        state_r <= ST_XP; // [R22]
                        cnt_r <= CNT_W'(XP_CYC - 1);
                    end
                end
                ST_XP:
                begin
                    if (cnt_done)
                        state_r <= ST_IDLE; // [R22]
                    else
                        cnt_r <= cnt_r - 1'b1;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
    // ******************************
    // Mode registers
    // ******************************
    logic mem_wr, mem_clr;
    // Read-only or unknown targets are simply dropped
    assign mem_wr = accept_mrw && mr_writable; // [R04]
    assign mem_clr = accept_mrw && ma == MA_RESET; // [R08]
    sdmzp_mr_mem u_mem
    (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .wr_en(mem_wr),
        .wr_addr(ma[1:0]),
        .wr_data(op),
        .clr_all(mem_clr),
        .rd_addr(MR_RD_ADDR), // [R07]
        .rd_data(MR_RD_DATA)
    );
    // ******************************
    // Drive impedance and calibration pin
    // ******************************
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            OUTPUT_DRIVE_IMPEDANCE <= DRIVE_DEFAULT;
            ZQ_CURRENT_ON <= 1'b0;
            zq_reset_r <= 1'b0;
        end
        else
        begin
            if (state_r == ST_IDLE && accept_mrw && zq_cmd && !zq_sup)
            begin
                ZQ_CURRENT_ON <= op != ZQ_RESET_CODE;
                zq_reset_r <= op == ZQ_RESET_CODE;
            end
            else if (state_r == ST_ZQ && cnt_done)
            begin
                ZQ_CURRENT_ON <= 1'b0; // [R16]
                OUTPUT_DRIVE_IMPEDANCE <= zq_reset_r ? DRIVE_DEFAULT : DRIVE_CAL; // [R12]
            end
            if (zq_sup || mem_clr)
                OUTPUT_DRIVE_IMPEDANCE <= DRIVE_DEFAULT; // [R15]
        end
    end
    // ******************************
    // Status outputs
    // ******************************
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            BUSY <= 1'b0;
            POWER_DOWN <= 1'b0;
            ACTIVE_PD <= 1'b0;
            BUFFERS_ON <= 1'b1;
            INIT_ACTIVE <= 1'b0;
        end
        else
        begin
            BUSY <= state_r inside {ST_MRW, ST_INIT, ST_ZQ};
            POWER_DOWN <= state_r == ST_PD; // [R21]
            BUFFERS_ON <= state_r != ST_PD; // [R20]
            if (state_r == ST_IDLE && is_pde)
                ACTIVE_PD <= bank_act;
            INIT_ACTIVE <= state_r == ST_INIT;
        end
    end
    // Flags for refused and illegal commands
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            ILLEGAL_CMD <= 1'b0;
            REJECTED_CMD <= 1'b0;
        end
        else
        begin
            ILLEGAL_CMD <= (state_r inside {ST_MRW, ST_INIT, ST_ZQ, ST_XP}) && cmd_start && !is_nop; // [R24]
            REJECTED_CMD <= state_r == ST_IDLE && is_mrw && bank_act; // [R25]
        end
    end
    // ******************************
    // Checks
    // ******************************
    a_mrw_busy: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R06]
        accept_mrw && mr_writable |=> state_r == ST_MRW [*2] ##1 state_r == ST_IDLE)
        else $error("write period wrong");
    a_active_reject: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R25]
        state_r == ST_IDLE && is_mrw && bank_act |=> REJECTED_CMD && $stable(state_r))
        else $error("active write not rejected");
    a_zq_ignored: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R15]
        zq_sup && accept_mrw && zq_cmd |=> state_r != ST_ZQ)
        else $error("calibration not ignored");
    a_zq_end: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R16]
        state_r == ST_ZQ && cnt_done |=> !ZQ_CURRENT_ON)
        else $error("calibration current left on");
    a_pd_entry: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R18]
        state_r == ST_IDLE && is_pde |=> state_r == ST_PD ##1 POWER_DOWN && !BUFFERS_ON)
        else $error("power-down not entered");
    a_pd_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R22]
        $rose(state_r == ST_PD) |-> state_r == ST_PD [*3])
        else $error("power-down left before tCKE");
    a_xp_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R22]
        $rose(state_r == ST_XP) |-> state_r == ST_XP [*3] ##1 state_r == ST_IDLE)
        else $error("exit latency wrong");
    a_ro_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R04]
        accept_mrw && !mr_writable && ma != MA_RESET |-> !mem_wr && !mem_clr)
        else $error("read-only register written");
    a_illegal: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R24]
        state_r inside {ST_MRW, ST_INIT, ST_ZQ} && cmd_start && !is_nop |=> ILLEGAL_CMD)
        else $error("illegal command not flagged");
    a_zq_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R10]
        accept_mrw && zq_cmd && !zq_sup && op != ZQ_RESET_CODE |=> ZQ_CURRENT_ON && state_r == ST_ZQ)
        else $error("calibration not started");
    a_init_entry: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R08]
        accept_mrw && ma == MA_RESET |=> state_r == ST_INIT ##1 INIT_ACTIVE && MR_RD_DATA == MR_DEFAULT)
        else $error("reset write did not initialise");
    a_strap_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R15]
        zq_sup |=> OUTPUT_DRIVE_IMPEDANCE == DRIVE_DEFAULT)
        else $error("drive not default with calibration pin at supply");
    a_pd_kind: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R20]
        state_r == ST_IDLE && is_pde |=> ACTIVE_PD == $past(bank_act))
        else $error("power-down kind wrong");
    a_xp_buffers: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R22]
        state_r == ST_XP |=> BUFFERS_ON)
        else $error("buffers off after exit");
    c_mrw: cover property (@(posedge CORE_CLK) disable iff (!RST_N) accept_mrw && mr_writable);
    c_zq: cover property (@(posedge CORE_CLK) disable iff (!RST_N) state_r == ST_ZQ && cnt_done);
    c_pd: cover property (@(posedge CORE_CLK) disable iff (!RST_N) state_r == ST_XP);
    c_reset: cover property (@(posedge CORE_CLK) disable iff (!RST_N) state_r == ST_INIT);
endmodule
`default_nettype wire

// File: verif/sdmzp_ctrl_model.sv
// Behavioural memory controller that drives the command pins of the block.
// Assumes the bench calls its tasks; pins change only at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module sdmzp_ctrl_model
(
    // Clock
    input wire logic clk,
    // Command pins
    output var logic cke,
    output var logic cs_n,
    output var logic [9:0] ca_rise,
    output var logic [9:0] ca_fall
);
    // ********************
    // Idle pins
    // ********************
    initial
    begin
        cke = 1'b1;
        cs_n = 1'b1;
        ca_rise = 10'h3A5;
        ca_fall = 10'h15A;
    end
    // One command: CA set up a cycle early, CS low two cycles so the input filter passes it,
    // then CA released to its inverse
    task automatic send(input logic [9:0] r, input logic [9:0] f);
        @(negedge clk);
        ca_rise = r;
        ca_fall = f;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        ca_rise = ~r;
        ca_fall = ~f;
    endtask
    // Mode register write: address split over both edges, data on the falling one
    task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
        send({ma[5:0], 4'h0}, {op, ma[7:6]});
    endtask
    // Power-down entry and exit keep CS high; only NOPs follow
    task automatic pd_enter();
        @(negedge clk);
        cke = 1'b0;
    endtask
    task automatic pd_exit();
        @(negedge clk);
        cke = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: verif/tb_sdmzp_top.sv
// Self-checking bench for the mode register, calibration and power-down block.
// Assumes the controller model drives the command pins; bench drives straps at falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_sdmzp_top;
    import sdmzp_pkg::*;
    typedef struct {logic [7:0] ma; logic [7:0] op; logic [1:0] a; logic [7:0] e;} sdmzp_row_type;
    logic CORE_CLK = 1'b0, RST_N = 1'b0, CKE, CS_N, BANK_ACTIVE = 1'b0, ZQ_AT_SUPPLY = 1'b0;
    logic [9:0] CA_RISE, CA_FALL;
    logic [1:0] MR_RD_ADDR = 2'h0;
    logic [7:0] MR_RD_DATA, rd;
    logic [3:0] OUTPUT_DRIVE_IMPEDANCE;
    logic BUSY, POWER_DOWN, ACTIVE_PD, BUFFERS_ON, ZQ_CURRENT_ON, ILLEGAL_CMD, REJECTED_CMD, INIT_ACTIVE;
    logic ill_seen, rej_seen, cur_seen, init_seen;
    int fail_count = 0, n_compared = 0, n;
    sdmzp_row_type rows[5] = '{'{8'h01, 8'h5A, 2'h1, 8'h5A}, '{8'h02, 8'hC3, 2'h2, 8'hC3},
        '{8'h03, 8'h0F, 2'h3, 8'h0F}, '{8'h00, 8'h77, 2'h0, 8'h00}, '{8'h41, 8'hFF, 2'h1, 8'h5A}};
    logic [7:0] zq_code[4] = '{ZQ_INIT_CODE, ZQ_LONG_CODE, ZQ_SHORT_CODE, ZQ_RESET_CODE};
    int zq_cyc[4] = '{ZQINIT_CYC, ZQCL_CYC, ZQCS_CYC, ZQRESET_CYC};
    logic [3:0] zq_drv[4] = '{DRIVE_CAL, DRIVE_CAL, DRIVE_CAL, DRIVE_DEFAULT};
    logic zq_cur[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    // ********************
    // Clock, design and controller
    // ********************
    always #2.5 CORE_CLK = ~CORE_CLK;
    sdmzp_top DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CKE(CKE), .CS_N(CS_N), .CA_RISE(CA_RISE),
        .CA_FALL(CA_FALL), .BANK_ACTIVE(BANK_ACTIVE), .ZQ_AT_SUPPLY(ZQ_AT_SUPPLY),
        .MR_RD_ADDR(MR_RD_ADDR), .MR_RD_DATA(MR_RD_DATA), .BUSY(BUSY), .POWER_DOWN(POWER_DOWN),
        .ACTIVE_PD(ACTIVE_PD), .BUFFERS_ON(BUFFERS_ON), .ZQ_CURRENT_ON(ZQ_CURRENT_ON),
        .OUTPUT_DRIVE_IMPEDANCE(OUTPUT_DRIVE_IMPEDANCE), .ILLEGAL_CMD(ILLEGAL_CMD),
        .REJECTED_CMD(REJECTED_CMD), .INIT_ACTIVE(INIT_ACTIVE));
    sdmzp_ctrl_model u_ctrl (.clk(CORE_CLK), .cke(CKE), .cs_n(CS_N), .ca_rise(CA_RISE), .ca_fall(CA_FALL));
    // Sticky views of pulses and levels, sampled where settled
    always @(negedge CORE_CLK)
    begin
        if (ILLEGAL_CMD === 1'b1) ill_seen = 1'b1;
        if (REJECTED_CMD === 1'b1) rej_seen = 1'b1;
        if (ZQ_CURRENT_ON === 1'b1) cur_seen = 1'b1;
        if (INIT_ACTIVE === 1'b1) init_seen = 1'b1;
    end
    // Verdict and end of run
    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard: the whole sequence needs under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge CORE_CLK);
        fail_count++;
        test_done();
    end
    // Waits for BUSY to rise, then counts its high cycles; bounded both ways
    task automatic wait_busy(output int cnt);
        cnt = 0;
        for (int i = 0; i < 20 && BUSY !== 1'b1; i++) @(negedge CORE_CLK);
        while (BUSY === 1'b1 && cnt < 400)
        begin
            cnt++;
            @(negedge CORE_CLK);
        end
    endtask
    // Side read of the mode register store, registered one cycle
    task automatic rd_mr(input logic [1:0] a, output logic [7:0] d);
        @(negedge CORE_CLK);
        MR_RD_ADDR = a;
        repeat (2) @(negedge CORE_CLK);
        d = MR_RD_DATA;
    endtask
    task automatic clr();
        ill_seen = 0; rej_seen = 0; cur_seen = 0; init_seen = 0;
    endtask
    // ********************
    // Main sequence
    // ********************
    initial
    begin
        clr();
        repeat (10) @(negedge CORE_CLK);
        RST_N = 1'b1;
        repeat (2) @(negedge CORE_CLK);
        `CHK("buffers_after_reset", 1'b1, BUFFERS_ON)
        `CHK("drive_after_reset", DRIVE_DEFAULT, OUTPUT_DRIVE_IMPEDANCE)
        `CHK("pd_after_reset", 1'b0, POWER_DOWN)
        // Writes, including read-only addresses; busy for the write period
        foreach (rows[i])
        begin
            clr();
            u_ctrl.mrw(rows[i].ma, rows[i].op);
            wait_busy(n);
            `CHK("mrw_busy_cycles", MRW_CYC, n)
            rd_mr(rows[i].a, rd);
            `CHK("mr_store", rows[i].e, rd)
            `CHK("mrw_no_flags", 1'b0, ill_seen | rej_seen)
        end
        // All four calibrations: busy length, drive code and calibration current
        foreach (zq_code[i])
        begin
            clr();
            u_ctrl.mrw(MA_ZQ, zq_code[i]);
            wait_busy(n);
            `CHK("zq_busy_cycles", zq_cyc[i], n)
            `CHK("zq_current_during", zq_cur[i], cur_seen)
            repeat (2) @(negedge CORE_CLK);
            `CHK("zq_current_after", 1'b0, ZQ_CURRENT_ON)
            `CHK("zq_drive", zq_drv[i], OUTPUT_DRIVE_IMPEDANCE)
        end
        // A write arriving inside a calibration is flagged and ignored
        clr();
        u_ctrl.mrw(MA_ZQ, ZQ_LONG_CODE);
        u_ctrl.send(10'h3FF, 10'h3FF);
        repeat (6) @(negedge CORE_CLK);
        `CHK("nop_not_illegal", 1'b0, ill_seen)
        u_ctrl.mrw(8'h01, 8'hEE);
        wait_busy(n);
        `CHK("illegal_flag", 1'b1, ill_seen)
        rd_mr(2'h1, rd);
        `CHK("illegal_no_write", 8'h5A, rd)
        // Calibration pin at supply: calibration ignored, default drive kept
        clr();
        ZQ_AT_SUPPLY = 1'b1;
        repeat (6) @(negedge CORE_CLK);
        u_ctrl.mrw(MA_ZQ, ZQ_INIT_CODE);
        wait_busy(n);
        `CHK("strap_busy_cycles", MRW_CYC, n)
        `CHK("strap_no_current", 1'b0, cur_seen)
        `CHK("strap_drive", DRIVE_DEFAULT, OUTPUT_DRIVE_IMPEDANCE)
        ZQ_AT_SUPPLY = 1'b0;
        // Write while a bank is active is refused without effect
        clr();
        BANK_ACTIVE = 1'b1;
        repeat (6) @(negedge CORE_CLK);
        u_ctrl.mrw(8'h02, 8'h99);
        repeat (10) @(negedge CORE_CLK);
        `CHK("reject_flag", 1'b1, rej_seen)
        rd_mr(2'h2, rd);
        `CHK("reject_no_write", 8'hC3, rd)
        // Active then idle power-down, entry and exit
        for (int ba = 1; ba >= 0; ba--)
        begin
            BANK_ACTIVE = ba[0];
            repeat (6) @(negedge CORE_CLK);
            u_ctrl.pd_enter();
            repeat (8) @(negedge CORE_CLK);
            `CHK("pd_entered", 1'b1, POWER_DOWN)
            `CHK("pd_buffers_off", 1'b0, BUFFERS_ON)
            `CHK("pd_kind", ba[0], ACTIVE_PD)
            repeat (CKE_CYC + 2) @(negedge CORE_CLK);
            u_ctrl.pd_exit();
            repeat (XP_CYC + 10) @(negedge CORE_CLK);
            `CHK("pd_exited", 1'b0, POWER_DOWN)
            `CHK("pd_buffers_on", 1'b1, BUFFERS_ON)
        end
        // Reset write: auto-initialisation, store and calibrated drive back to defaults
        u_ctrl.mrw(MA_ZQ, ZQ_LONG_CODE);
        wait_busy(n);
        `CHK("pre_init_drive", DRIVE_CAL, OUTPUT_DRIVE_IMPEDANCE)
        clr();
        u_ctrl.mrw(MA_RESET, 8'h00);
        wait_busy(n);
        `CHK("init_busy_cycles", INIT_CYC, n)
        `CHK("init_active", 1'b1, init_seen)
        rd_mr(2'h1, rd);
        `CHK("init_store_default", MR_DEFAULT, rd)
        `CHK("init_drive_default", DRIVE_DEFAULT, OUTPUT_DRIVE_IMPEDANCE)
        test_done();
    end
endmodule
`default_nettype wire
